/* File: bench/rxcf_regs_chk.sv */
`timescale 1ns/1ns
`default_nettype none
module rxcf_regs_chk (
  // bus and clock
  input wire logic        CLK_I, RST_I, REQ_I, WR_I, RVALID_O,
  input wire logic [5:0]  ADDR_I,
  input wire logic [3:0]  WDATA_I, RDATA_O,
  // configuration and settle status
  input wire logic        TEST_MODE_ACTIVE_O, CLOCK_HOLD_EN_O,
  input wire logic        CLK_SETTLE_BUSY_O, CLK_SETTLE_DONE_O,
  input wire logic [5:0]  CLK_LANE_SETTLE_COUNT_O, DATA_LANE_SETTLE_COUNT_O,
  input wire logic [5:0]  TEST_MODE_SELECT_O,
  input wire logic [31:0] SELFTEST_PATTERN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire rd = REQ_I && !WR_I;
  wire wr = REQ_I && WR_I;
  a_read_valid: assert property (rd |=> RVALID_O)
    else $error("read valid missing");
  a_no_stray_valid: assert property (!rd |=> !RVALID_O)
    else $error("stray read valid");
  a_unmapped_zero: assert property (rd && ADDR_I == 6'h3F
    |=> RDATA_O == 4'h0) else $error("unmapped read not zero");
  a_clk_mid_wr: assert property (wr && ADDR_I == 6'h0B
    |=> CLK_LANE_SETTLE_COUNT_O[4:1] == $past(WDATA_I)) else $error("clk mid");
  a_clk_top_wr: assert property (wr && ADDR_I == 6'h0C
    |=> CLK_LANE_SETTLE_COUNT_O[5] == $past(WDATA_I[0]))
    else $error("clk top");
  a_data_low_wr: assert property (wr && ADDR_I == 6'h0F
    |=> DATA_LANE_SETTLE_COUNT_O[1:0] == $past(WDATA_I[3:2]))
    else $error("data lo");
  a_data_high_wr: assert property (wr && ADDR_I == 6'h10
    |=> DATA_LANE_SETTLE_COUNT_O[5:2] == $past(WDATA_I))
    else $error("data hi");
  a_test_sel_wr: assert property (wr && ADDR_I == 6'h15
    |=> TEST_MODE_SELECT_O[5:2] == $past(WDATA_I))
    else $error("test hi");
  a_test_active: assert property (
    TEST_MODE_ACTIVE_O == |TEST_MODE_SELECT_O)
    else $error("test active mismatch");
  a_pattern_wr: assert property (wr && ADDR_I inside {[6'h16:6'h1D]} |=>
    SELFTEST_PATTERN_O[{$past(ADDR_I[2:0]) - 3'h6, 2'b00} +: 4]
    == $past(WDATA_I)) else $error("pattern nibble");
  a_hold_wr: assert property (wr && ADDR_I == 6'h1E
    |=> CLOCK_HOLD_EN_O == $past(WDATA_I[0])) else $error("clock hold");
  a_settle_end: assert property (CLK_SETTLE_DONE_O
    |-> $past(CLK_SETTLE_BUSY_O) && !CLK_SETTLE_BUSY_O)
    else $error("settle end");
  c_read: cover property (rd);
  c_done: cover property (CLK_SETTLE_DONE_O);
  c_test: cover property (TEST_MODE_ACTIVE_O);
endmodule // rxcf_regs_chk
bind rxcf_regs rxcf_regs_chk u_chk (
  .CLK_I                    (CLK_I),
  .RST_I                    (RST_I),
  .REQ_I                    (REQ_I),
  .WR_I                     (WR_I),
  .RVALID_O                 (RVALID_O),
  .ADDR_I                   (ADDR_I),
  .WDATA_I                  (WDATA_I),
  .RDATA_O                  (RDATA_O),
  .TEST_MODE_ACTIVE_O       (TEST_MODE_ACTIVE_O),
  .CLOCK_HOLD_EN_O          (CLOCK_HOLD_EN_O),
  .CLK_SETTLE_BUSY_O        (CLK_SETTLE_BUSY_O),
  .CLK_SETTLE_DONE_O        (CLK_SETTLE_DONE_O),
  .CLK_LANE_SETTLE_COUNT_O  (CLK_LANE_SETTLE_COUNT_O),
  .DATA_LANE_SETTLE_COUNT_O (DATA_LANE_SETTLE_COUNT_O),
  .TEST_MODE_SELECT_O       (TEST_MODE_SELECT_O),
  .SELFTEST_PATTERN_O       (SELFTEST_PATTERN_O)
);
`default_nettype wire

/* File: bench/tb_rxcf_regs.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_rxcf_regs;
  logic        CLK_I = 0, RST_I = 1, REQ_I = 0, WR_I = 0, RVALID_O;
  logic        CLK_SETTLE_START_I = 0, DAT_SETTLE_START_I = 0;
  logic [5:0]  ADDR_I = 6'h00;
  logic [3:0]  WDATA_I = 4'h0, RDATA_O;
  logic        CLK_SETTLE_BUSY_O, CLK_SETTLE_DONE_O, DAT_SETTLE_BUSY_O;
  logic        DAT_SETTLE_DONE_O, TEST_MODE_ACTIVE_O, CLOCK_HOLD_EN_O;
  logic [5:0]  CLK_LANE_SETTLE_COUNT_O, DATA_LANE_SETTLE_COUNT_O;
  logic [5:0]  TEST_MODE_SELECT_O;
  logic [31:0] SELFTEST_PATTERN_O;
  logic [3:0]  m [0:63];
  integer      seed = 99070, err_total = 0, comparisons = 0, r, a;
  rxcf_regs dut (
    .CLK_I                    (CLK_I),
    .RST_I                    (RST_I),
    .REQ_I                    (REQ_I),
    .WR_I                     (WR_I),
    .ADDR_I                   (ADDR_I),
    .WDATA_I                  (WDATA_I),
    .RDATA_O                  (RDATA_O),
    .RVALID_O                 (RVALID_O),
    .CLK_SETTLE_START_I       (CLK_SETTLE_START_I),
    .DAT_SETTLE_START_I       (DAT_SETTLE_START_I),
    .CLK_SETTLE_BUSY_O        (CLK_SETTLE_BUSY_O),
    .CLK_SETTLE_DONE_O        (CLK_SETTLE_DONE_O),
    .DAT_SETTLE_BUSY_O        (DAT_SETTLE_BUSY_O),
    .DAT_SETTLE_DONE_O        (DAT_SETTLE_DONE_O),
    .CLK_LANE_SETTLE_COUNT_O  (CLK_LANE_SETTLE_COUNT_O),
    .DATA_LANE_SETTLE_COUNT_O (DATA_LANE_SETTLE_COUNT_O),
    .TEST_MODE_SELECT_O       (TEST_MODE_SELECT_O),
    .TEST_MODE_ACTIVE_O       (TEST_MODE_ACTIVE_O),
    .SELFTEST_PATTERN_O       (SELFTEST_PATTERN_O),
    .CLOCK_HOLD_EN_O          (CLOCK_HOLD_EN_O)
  );
  initial forever #4 CLK_I = ~CLK_I;
  function automatic bit mapped(input logic [5:0] x);
    return x inside {6'h0B, 6'h0C, 6'h0F, 6'h10, [6'h14:6'h1E]};
  endfunction
  function automatic logic [3:0] msk(input logic [5:0] x);
    return (x == 6'h0C || x == 6'h1E) ? 4'h1 :
      (x == 6'h0F || x == 6'h14) ? 4'hC : 4'hF;
  endfunction
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic conclude;
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [5:0] ad,
                     input logic [3:0] d);
    @(negedge CLK_I);
    {REQ_I, WR_I, ADDR_I, WDATA_I} = {1'b1, w, ad, d};
    @(negedge CLK_I);
    REQ_I = 0;
    if (w && (mapped(ad) || ad == 6'h0A)) m[ad] = d;
    if (!w) chk("rvalid", 1, RVALID_O);
    if (!w) chk("rdata", ad == 6'h0A ? {m[10][3], 3'h0} :
      mapped(ad) ? m[ad] : 4'h0, RDATA_O);
  endtask
  task automatic settle(input logic k, input logic [5:0] n);
    integer c;
    c = 0;
    @(negedge CLK_I);
    {CLK_SETTLE_START_I, DAT_SETTLE_START_I} = {k, !k};
    @(negedge CLK_I);
    {CLK_SETTLE_START_I, DAT_SETTLE_START_I} = 2'b00;
    while ((k ? CLK_SETTLE_DONE_O : DAT_SETTLE_DONE_O) !== 1'b1
           && c < 100) begin
      c += k ? CLK_SETTLE_BUSY_O : DAT_SETTLE_BUSY_O;
      @(negedge CLK_I);
    end
    chk("settle_done", 1,
      k ? CLK_SETTLE_DONE_O : DAT_SETTLE_DONE_O);
    chk("settle_len", n + 1, c);
  endtask
  initial begin
    #100000;
    err_total++;
    conclude;
  end
  initial begin
    repeat (8) @(posedge CLK_I);
    @(negedge CLK_I) RST_I = 0;
    for (r = 0; r < 4; r++) begin
      for (a = 0; a < 64; a++)
        acc(1, a[5:0], r ? 4'($random(seed)) & msk(a[5:0]) : 4'h0);
      for (a = 10; a < 31; a++) acc(0, a[5:0], 4'h0);
      acc(0, 6'h3F, 4'h0);
      chk("clk_cnt", {m[12][0], m[11], m[10][3]},
        CLK_LANE_SETTLE_COUNT_O);
      chk("dat_cnt", {m[16], m[15][3:2]}, DATA_LANE_SETTLE_COUNT_O);
      chk("test_sel", {m[21], m[20][3:2]}, TEST_MODE_SELECT_O);
      chk("test_act", |{m[21], m[20][3:2]}, TEST_MODE_ACTIVE_O);
      chk("pattern", {m[29], m[28], m[27], m[26],
        m[25], m[24], m[23], m[22]}, SELFTEST_PATTERN_O);
      chk("hold", m[30][0], CLOCK_HOLD_EN_O);
      settle(1, {m[12][0], m[11], m[10][3]});
      settle(0, {m[16], m[15][3:2]});
    end
    conclude;
  end
endmodule // tb_rxcf_regs
`default_nettype wire

/* File: verilog/rxcf_defs.vh */
// Summary of operation
// RQ1: clock settle count N: 4:1 at 0x0B, 5 at 0x0C[0]; N+1 periods
// RQ2: data settle count M: 1:0 at 0x0F[3:2], 5:2 at 0x10; M+1 periods
// RQ3: six-bit test select at 0x14[3:2] and 0x15; nonzero selects a test mode
// RQ4: 32-bit self-test pattern in nibbles 0x16 to 0x1D; generator and matcher (here the pattern is only held and driven out on SELFTEST_PATTERN_O)
// RQ5: 0x1E bit 0 keeps clock lane in high-speed receive with continuous clock
// RQ6: software writes zeros into reserved bits of 0x0C, 0x0F, 0x14 and 0x1E
// RQ7: registers reached only over the config bus with six-bit offsets
`ifndef RXCF_DEFS_VH
`define RXCF_DEFS_VH
`define RXCF_AW           6
`define RXCF_DW           4
`define RXCF_CLK_SETTLE0  6'h0A
`define RXCF_CLK_MID      6'h0B
`define RXCF_CLK_TOP      6'h0C
`define RXCF_DAT_LOW      6'h0F
`define RXCF_DAT_HIGH     6'h10
`define RXCF_TEST_LOW     6'h14
`define RXCF_TEST_HIGH    6'h15
`define RXCF_PAT_FIRST    6'h16
`define RXCF_PAT1         6'h17
`define RXCF_PAT2         6'h18
`define RXCF_PAT3         6'h19
`define RXCF_PAT4         6'h1A
`define RXCF_PAT5         6'h1B
`define RXCF_PAT6         6'h1C
`define RXCF_PAT_LAST     6'h1D
`define RXCF_CLK_B0_BIT   3
`define RXCF_CLK_B5_BIT   0
`define RXCF_PAIR_MSB     3
`define RXCF_PAIR_LSB     2
`define RXCF_HOLD_BIT     0
`define RXCF_ZERO3        3'h0
`define RXCF_HOLD         6'h1E
`define RXCF_ZERO4        4'h0
`define RXCF_ZERO6        6'h00
`define RXCF_ONE6         6'h01
`define RXCF_ZERO7        7'h00
`define RXCF_ONE7         7'h01
`endif

/* File: verilog/rxcf_regs.v */
`timescale 1ns/1ns
`default_nettype none
`include "rxcf_defs.vh"
module rxcf_regs (
  // clock and reset
  input  wire        CLK_I,
  input  wire        RST_I,
  // config bus
  input  wire        REQ_I,
  input  wire        WR_I,
  input  wire [5:0]  ADDR_I,
  input  wire [3:0]  WDATA_I,
  output reg  [3:0]  RDATA_O,
  output reg         RVALID_O,
  // settle start events
  input  wire        CLK_SETTLE_START_I,
  input  wire        DAT_SETTLE_START_I,
  // settle status
  output wire        CLK_SETTLE_BUSY_O,
  output wire        CLK_SETTLE_DONE_O,
  output wire        DAT_SETTLE_BUSY_O,
  output wire        DAT_SETTLE_DONE_O,
  // configuration outputs
  output wire [5:0]  CLK_LANE_SETTLE_COUNT_O,
  output wire [5:0]  DATA_LANE_SETTLE_COUNT_O,
  output wire [5:0]  TEST_MODE_SELECT_O,
  output wire        TEST_MODE_ACTIVE_O,
  output wire [31:0] SELFTEST_PATTERN_O,
  output wire        CLOCK_HOLD_EN_O
);
  // register storage
  reg         clk_settle0;
  reg  [3:0]  clk_settle_mid;
  reg  [3:0]  clk_settle_top;
  reg  [3:0]  data_settle_low;
  reg  [3:0]  data_settle_high;
  reg  [3:0]  test_mode_low;
  reg  [3:0]  test_mode_high;
  reg  [3:0]  selftest_nibble0;
  reg  [3:0]  selftest_nibble1;
  reg  [3:0]  selftest_nibble2;
  reg  [3:0]  selftest_nibble3;
  reg  [3:0]  selftest_nibble4;
  reg  [3:0]  selftest_nibble5;
  reg  [3:0]  selftest_nibble6;
  reg  [3:0]  selftest_nibble7;
  reg  [3:0]  clock_hold_ctrl;
  // bus decode
  wire        wr;
  wire        rd;
  wire        we_clk0;
  wire        we_clk_mid;
  wire        we_clk_top;
  wire        we_dat_low;
  wire        we_dat_high;
  wire        we_test_low;
  wire        we_test_high;
  wire [7:0]  we_pat;
  wire        we_hold;
  // read path
  reg  [3:0]  next_rdata;

  // true when the offset on the bus names the given register
  function hit;
    input [5:0] addr;
    input [5:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // joins a four-bit upper part with the top pair of a lower nibble
  function [5:0] join_pair;
    input [3:0] upper;
    input [3:0] lower;
    begin
      join_pair = {upper, lower[`RXCF_PAIR_MSB:`RXCF_PAIR_LSB]};
    end
  endfunction

  // write strobes, config bus only
  assign wr           = REQ_I & WR_I; // RQ7
  assign rd           = REQ_I & ~WR_I; // RQ7
  assign we_clk0      = wr & hit(ADDR_I, `RXCF_CLK_SETTLE0);
  assign we_clk_mid   = wr & hit(ADDR_I, `RXCF_CLK_MID);
  assign we_clk_top   = wr & hit(ADDR_I, `RXCF_CLK_TOP);
  assign we_dat_low   = wr & hit(ADDR_I, `RXCF_DAT_LOW);
  assign we_dat_high  = wr & hit(ADDR_I, `RXCF_DAT_HIGH);
  assign we_test_low  = wr & hit(ADDR_I, `RXCF_TEST_LOW);
  assign we_test_high = wr & hit(ADDR_I, `RXCF_TEST_HIGH);
  assign we_pat[0]    = wr & hit(ADDR_I, `RXCF_PAT_FIRST);
  assign we_pat[1]    = wr & hit(ADDR_I, `RXCF_PAT1);
  assign we_pat[2]    = wr & hit(ADDR_I, `RXCF_PAT2);
  assign we_pat[3]    = wr & hit(ADDR_I, `RXCF_PAT3);
  assign we_pat[4]    = wr & hit(ADDR_I, `RXCF_PAT4);
  assign we_pat[5]    = wr & hit(ADDR_I, `RXCF_PAT5);
  assign we_pat[6]    = wr & hit(ADDR_I, `RXCF_PAT6);
  assign we_pat[7]    = wr & hit(ADDR_I, `RXCF_PAT_LAST);
  assign we_hold      = wr & hit(ADDR_I, `RXCF_HOLD);

  // write side; reserved bits are stored as written and read back
  always @(posedge CLK_I) begin
    if (RST_I) begin
      clk_settle0      <= 1'b0;
      clk_settle_mid   <= `RXCF_ZERO4;
      clk_settle_top   <= `RXCF_ZERO4;
      data_settle_low  <= `RXCF_ZERO4;
      data_settle_high <= `RXCF_ZERO4;
      test_mode_low    <= `RXCF_ZERO4;
      test_mode_high   <= `RXCF_ZERO4;
      selftest_nibble0 <= `RXCF_ZERO4;
      selftest_nibble1 <= `RXCF_ZERO4;
      selftest_nibble2 <= `RXCF_ZERO4;
      selftest_nibble3 <= `RXCF_ZERO4;
      selftest_nibble4 <= `RXCF_ZERO4;
      selftest_nibble5 <= `RXCF_ZERO4;
      selftest_nibble6 <= `RXCF_ZERO4;
      selftest_nibble7 <= `RXCF_ZERO4;
      clock_hold_ctrl  <= `RXCF_ZERO4;
    end else begin
      if (we_clk0) begin
        clk_settle0 <= WDATA_I[`RXCF_CLK_B0_BIT]; // RQ1
      end
      if (we_clk_mid) begin
        clk_settle_mid <= WDATA_I; // RQ1
      end
      if (we_clk_top) begin
        clk_settle_top <= WDATA_I; // RQ1
      end
      if (we_dat_low) begin
        data_settle_low <= WDATA_I; // RQ2
      end
      if (we_dat_high) begin
        data_settle_high <= WDATA_I; // RQ2
      end
      if (we_test_low) begin
        test_mode_low <= WDATA_I; // RQ3
      end
      if (we_test_high) begin
        test_mode_high <= WDATA_I; // RQ3
      end
      if (we_pat[0]) begin
        selftest_nibble0 <= WDATA_I; // RQ4
      end
      if (we_pat[1]) begin
        selftest_nibble1 <= WDATA_I; // RQ4
      end
      if (we_pat[2]) begin
        selftest_nibble2 <= WDATA_I; // RQ4
      end
      if (we_pat[3]) begin
        selftest_nibble3 <= WDATA_I; // RQ4
      end
      if (we_pat[4]) begin
        selftest_nibble4 <= WDATA_I; // RQ4
      end
      if (we_pat[5]) begin
        selftest_nibble5 <= WDATA_I; // RQ4
      end
      if (we_pat[6]) begin
        selftest_nibble6 <= WDATA_I; // RQ4
      end
      if (we_pat[7]) begin
        selftest_nibble7 <= WDATA_I; // RQ4
      end
      if (we_hold) begin
        clock_hold_ctrl <= WDATA_I; // RQ5
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    next_rdata = `RXCF_ZERO4;
    case (ADDR_I)
      `RXCF_CLK_SETTLE0: next_rdata = {clk_settle0, `RXCF_ZERO3};
      `RXCF_CLK_MID:     next_rdata = clk_settle_mid;
      `RXCF_CLK_TOP:     next_rdata = clk_settle_top;
      `RXCF_DAT_LOW:     next_rdata = data_settle_low;
      `RXCF_DAT_HIGH:    next_rdata = data_settle_high;
      `RXCF_TEST_LOW:    next_rdata = test_mode_low;
      `RXCF_TEST_HIGH:   next_rdata = test_mode_high;
      `RXCF_PAT_FIRST:   next_rdata = selftest_nibble0;
      `RXCF_PAT1:        next_rdata = selftest_nibble1;
      `RXCF_PAT2:        next_rdata = selftest_nibble2;
      `RXCF_PAT3:        next_rdata = selftest_nibble3;
      `RXCF_PAT4:        next_rdata = selftest_nibble4;
      `RXCF_PAT5:        next_rdata = selftest_nibble5;
      `RXCF_PAT6:        next_rdata = selftest_nibble6;
      `RXCF_PAT_LAST:    next_rdata = selftest_nibble7;
      `RXCF_HOLD:        next_rdata = clock_hold_ctrl;
      default:           next_rdata = `RXCF_ZERO4;
    endcase
  end

  // read answer one cycle after the request; data holds until next read
  always @(posedge CLK_I) begin
    if (RST_I) begin
      RDATA_O  <= `RXCF_ZERO4;
      RVALID_O <= 1'b0;
    end else begin
      RVALID_O <= rd; // RQ7
      if (rd) begin
        RDATA_O <= next_rdata; // RQ7
      end
    end
  end

  // configuration outputs straight from the register bits
  assign CLK_LANE_SETTLE_COUNT_O  = {clk_settle_top[`RXCF_CLK_B5_BIT],
                                     clk_settle_mid,
                                     clk_settle0}; // RQ1
  assign DATA_LANE_SETTLE_COUNT_O = join_pair(data_settle_high,
                                              data_settle_low); // RQ2
  assign TEST_MODE_SELECT_O       = join_pair(test_mode_high,
                                              test_mode_low); // RQ3
  assign TEST_MODE_ACTIVE_O       =
    (TEST_MODE_SELECT_O != `RXCF_ZERO6); // RQ3
  assign SELFTEST_PATTERN_O       = {selftest_nibble7, selftest_nibble6,
                                     selftest_nibble5, selftest_nibble4,
                                     selftest_nibble3, selftest_nibble2,
                                     selftest_nibble1,
                                     selftest_nibble0}; // RQ4
  assign CLOCK_HOLD_EN_O          = clock_hold_ctrl[`RXCF_HOLD_BIT]; // RQ5

  rxcf_settle_timer #(.W(6)) u_clk_timer (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .start_i (CLK_SETTLE_START_I),
    .count_i (CLK_LANE_SETTLE_COUNT_O), // RQ1
    .busy_o  (CLK_SETTLE_BUSY_O),
    .done_o  (CLK_SETTLE_DONE_O)
  );

  rxcf_settle_timer #(.W(6)) u_dat_timer (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .start_i (DAT_SETTLE_START_I),
    .count_i (DATA_LANE_SETTLE_COUNT_O), // RQ2
    .busy_o  (DAT_SETTLE_BUSY_O),
    .done_o  (DAT_SETTLE_DONE_O)
  );
endmodule // rxcf_regs
`default_nettype wire

/* File: verilog/rxcf_settle_timer.v */
`timescale 1ns/1ns
`default_nettype none
`include "rxcf_defs.vh"
// counts count+1 sync-clock periods after start
module rxcf_settle_timer #(
  parameter W = 6
) (
  // clock and reset
  input  wire         clk_i,
  input  wire         rst_i,
  // control
  input  wire         start_i,
  input  wire [W-1:0] count_i,
  // status
  output reg          busy_o,
  output reg          done_o
);
  reg [W:0] remain;

  always @(posedge clk_i) begin
    if (rst_i) begin
      remain <= `RXCF_ZERO7;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        remain <= {1'b0, count_i} + `RXCF_ONE7;
        busy_o <= 1'b1;
      end else if (busy_o) begin
        if (remain == `RXCF_ONE7) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        remain <= remain - `RXCF_ONE7;
      end
    end
  end
endmodule // rxcf_settle_timer
`default_nettype wire
